// File: src/ccoc_pkg.sv
// Package of constants for the clock channel output configuration block.
// Assumes an 8-bit register port with byte-wide registers at byte offsets.
package ccoc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets.
    localparam logic [7:0] OFF_CH4_DIV = 8'h26;
    localparam logic [7:0] OFF_CH5_CTL = 8'h27;
    localparam logic [7:0] OFF_CH4_SRC = 8'h30;
    localparam logic [7:0] OFF_STATUS = 8'h31;

    // Reset values.
    localparam logic [7:0] RST_CH4_DIV = 8'h02;
    localparam logic [7:0] RST_CH5_CTL = 8'h18;
    localparam logic [7:0] RST_CH4_SRC = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // Field positions: low bit of each 2-bit field, and the single doubler bit.
    localparam int CTL_SRC_LSB = 6;
    localparam int CTL_FMT_LSB = 4;
    localparam int CTL_MODEA_LSB = 2;
    localparam int CTL_MODEB_LSB = 0;
    localparam int SRC4_SEL_LSB = 0;
    localparam int SRC4_DBL_BIT = 2;

    // Status bit positions.
    localparam int ST_CH4_VALID = 0;
    localparam int ST_CH4_BYPASS = 1;
    localparam int ST_CH5_VALID = 2;
    localparam int ST_CH5_ACTIVE = 3;

    // Source select codes.
    localparam logic [1:0] SRC_SYNTH = 2'h0;
    localparam logic [1:0] SRC_RSVD = 2'h1;
    localparam logic [1:0] SRC_PRI = 2'h2;
    localparam logic [1:0] SRC_SEC = 2'h3;

    // Driver format codes.
    localparam logic [1:0] FMT_OFF = 2'h0;
    localparam logic [1:0] FMT_ACDIFF = 2'h1;
    localparam logic [1:0] FMT_HCSL = 2'h2;
    localparam logic [1:0] FMT_CMOS = 2'h3;

    // Single-ended pin modes.
    localparam logic [1:0] PIN_OFF_Z = 2'h0;
    localparam logic [1:0] PIN_OFF_LOW = 2'h1;
    localparam logic [1:0] PIN_INV = 2'h2;
    localparam logic [1:0] PIN_TRUE = 2'h3;

    // Tail currents in mA and loads in ohms.
    localparam logic [4:0] TAIL_NONE = 5'h00;
    localparam logic [4:0] TAIL_4MA = 5'h04;
    localparam logic [4:0] TAIL_6MA = 5'h06;
    localparam logic [4:0] TAIL_8MA = 5'h08;
    localparam logic [4:0] TAIL_16MA = 5'h10;
    localparam logic [7:0] LOAD_NONE = 8'h00;
    localparam logic [7:0] LOAD_50 = 8'h32;
    localparam logic [7:0] LOAD_100 = 8'h64;
    localparam logic [7:0] LOAD_200 = 8'hc8;

    // Indices of the synchronised clock inputs.
    localparam int IN_SYNTH = 0;
    localparam int IN_PRI = 1;
    localparam int IN_SEC = 2;
    localparam int IN_PRI_X2 = 3;
    localparam int IN_SEC_X2 = 4;
    localparam int N_IN = 5;
endpackage

// File: src/ccoc_sync.sv
// Two-flop synchroniser for one level coming from outside the clock domain.
// Assumes the input changes slower than the system clock for a clean copy.
module ccoc_sync (
    input wire logic clock,
    input wire logic srst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;
    logic sync_r;

    // Only the second flop is read outside; the first may go metastable.
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // ccoc_sync

// File: src/ccoc_divider.sv
// Integer post-divider: divides a sampled clock level by ratio_code plus one.
// Assumes src_level is already synchronised to clock.
module ccoc_divider (
    input wire logic clock,
    input wire logic srst,
    input wire logic src_level,
    input wire logic [7:0] ratio_code,
    input wire logic bypass,
    output logic out_level
);
    logic prev_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic out_r;

    // Next count on a source rising edge; wraps at the programmed code.
    always_comb begin
        cnt_nxt = cnt_r;
        if (cnt_r >= ratio_code) begin
            cnt_nxt = 8'h00;
        end else begin
            cnt_nxt = 8'(cnt_r + 8'h01);
        end
    end

    // Edge memory for the source level.
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= src_level;
        end
    end

    // Count source edges; the high phase is the first half of each period.
    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_r <= 8'h00;
            out_r <= 1'b0;
        end else if (bypass || (ratio_code == 8'h00)) begin
            cnt_r <= 8'h00;
            out_r <= src_level;
        end else if (src_level && !prev_r) begin
            cnt_r <= cnt_nxt;
            out_r <= (cnt_nxt <= (ratio_code >> 1));
        end
    end

    assign out_level = out_r;
endmodule // ccoc_divider

// File: src/clock_channel_output_config.sv
// Configuration registers and output path of two clock channels.
// Assumes clock inputs are slow beside the 50 MHz clock and are sampled.
//
// Implementation choice: the address-and-strobe port.
module clock_channel_output_config (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    input wire logic second_synth_output,
    input wire logic primary_ref_in,
    input wire logic secondary_ref_in,
    input wire logic primary_ref_doubled_in,
    input wire logic secondary_ref_doubled_in,
    output logic ch4_clock_out,
    output logic ch5_out_p,
    output logic ch5_out_p_oe_n,
    output logic ch5_out_n,
    output logic ch5_out_n_oe_n,
    output logic [4:0] ch5_tail_current_ma,
    output logic [7:0] ch5_load_ohms,
    output logic ch5_load_enabled
);
    logic [ccoc_pkg::N_IN-1:0] raw_in;
    logic [ccoc_pkg::N_IN-1:0] lvl;
    logic [7:0] ch4_div_r;
    logic [7:0] ch5_ctl_r;
    logic [7:0] ch4_src_r;
    logic [7:0] read_data_r;
    logic [7:0] read_data_nxt;
    logic [7:0] status;
    logic [1:0] ch5_source_select;
    logic [1:0] ch5_format;
    logic [1:0] ch5_drive_mode_a;
    logic [1:0] ch5_drive_mode_b;
    logic [1:0] ch4_source_select;
    logic doubler_en;
    logic [1:0] ch4_pick;
    logic [1:0] ch5_pick;
    logic ch4_bypass;
    logic ch4_div_level;
    logic ch5_level;
    logic ch5_valid;
    logic ch5_active;
    logic [1:0] p_pin;
    logic [1:0] n_pin;
    logic p_out_nxt;
    logic p_oe_n_nxt;
    logic n_out_nxt;
    logic n_oe_n_nxt;
    logic [4:0] tail_nxt;
    logic [7:0] load_nxt;
    logic load_en_nxt;
    logic p_out_r;
    logic p_oe_n_r;
    logic n_out_r;
    logic n_oe_n_r;
    logic [4:0] tail_r;
    logic [7:0] load_r;
    logic load_en_r;

    // Picks a source level; bit 1 flags a usable source, bit 0 is the level.
    function automatic logic [1:0] pick_source(
        input logic [1:0] sel,
        input logic dbl,
        input logic [ccoc_pkg::N_IN-1:0] levels
    );
        logic [1:0] res;
        res = 2'h0;
        case (sel)
            ccoc_pkg::SRC_SYNTH: res = {1'b1, levels[ccoc_pkg::IN_SYNTH]};
            ccoc_pkg::SRC_PRI: res = {1'b1, dbl ? levels[ccoc_pkg::IN_PRI_X2]
                                               : levels[ccoc_pkg::IN_PRI]};
            ccoc_pkg::SRC_SEC: res = {1'b1, dbl ? levels[ccoc_pkg::IN_SEC_X2]
                                               : levels[ccoc_pkg::IN_SEC]};
            default: res = 2'h0;
        endcase
        return res;
    endfunction

    // Single-ended pin decode; returns output enable (low active) and level.
    function automatic logic [1:0] cmos_pin(
        input logic [1:0] mode,
        input logic level
    );
        logic [1:0] res;
        res = 2'h2;
        case (mode)
            ccoc_pkg::PIN_OFF_Z: res = {1'b1, 1'b0};
            ccoc_pkg::PIN_OFF_LOW: res = {1'b0, 1'b0};
            ccoc_pkg::PIN_INV: res = {1'b0, ~level};
            ccoc_pkg::PIN_TRUE: res = {1'b0, level};
            default: res = {1'b1, 1'b0};
        endcase
        return res;
    endfunction

    // The clock inputs come from other domains, so each is synchronised.
    assign raw_in[ccoc_pkg::IN_SYNTH] = second_synth_output;
    assign raw_in[ccoc_pkg::IN_PRI] = primary_ref_in;
    assign raw_in[ccoc_pkg::IN_SEC] = secondary_ref_in;
    assign raw_in[ccoc_pkg::IN_PRI_X2] = primary_ref_doubled_in;
    assign raw_in[ccoc_pkg::IN_SEC_X2] = secondary_ref_doubled_in;

    generate
        for (genvar i = 0; i < ccoc_pkg::N_IN; i++) begin : g_sync
            ccoc_sync u_sync (
                .clock(clock),
                .srst(srst),
                .async_in(raw_in[i]),
                .sync_out(lvl[i])
            );
        end
    endgenerate

    // Field views of the control registers.
    assign ch5_source_select = ch5_ctl_r[ccoc_pkg::CTL_SRC_LSB+1:ccoc_pkg::CTL_SRC_LSB];
    assign ch5_format = ch5_ctl_r[ccoc_pkg::CTL_FMT_LSB+1:ccoc_pkg::CTL_FMT_LSB];
    assign ch5_drive_mode_a = ch5_ctl_r[ccoc_pkg::CTL_MODEA_LSB+1:ccoc_pkg::CTL_MODEA_LSB];
    assign ch5_drive_mode_b = ch5_ctl_r[ccoc_pkg::CTL_MODEB_LSB+1:ccoc_pkg::CTL_MODEB_LSB];
    assign ch4_source_select = ch4_src_r[ccoc_pkg::SRC4_SEL_LSB+1:ccoc_pkg::SRC4_SEL_LSB];
    assign doubler_en = ch4_src_r[ccoc_pkg::SRC4_DBL_BIT];

    always_ff @(posedge clock) begin
        if (srst) begin
            ch4_div_r <= ccoc_pkg::RST_CH4_DIV;
        end else if (write_strobe && (address == ccoc_pkg::OFF_CH4_DIV)) begin
            ch4_div_r <= write_data;
        end
    end

    // Channel 5 output control register.
    always_ff @(posedge clock) begin
        if (srst) begin
            ch5_ctl_r <= ccoc_pkg::RST_CH5_CTL;
        end else if (write_strobe && (address == ccoc_pkg::OFF_CH5_CTL)) begin
            ch5_ctl_r <= write_data;
        end
    end

    // Channel 4 source and doubler enable; upper bits are not stored.
    always_ff @(posedge clock) begin
        if (srst) begin
            ch4_src_r <= ccoc_pkg::RST_CH4_SRC;
        end else if (write_strobe && (address == ccoc_pkg::OFF_CH4_SRC)) begin
            ch4_src_r <= {5'h00, write_data[2:0]};
        end
    end

    assign ch4_pick = pick_source(ch4_source_select, doubler_en, lvl);
    assign ch5_pick = pick_source(ch5_source_select, doubler_en, lvl);

    // reference bypass
    // A reference or a reserved code skips the divider, which then idles.
    assign ch4_bypass = (ch4_source_select != ccoc_pkg::SRC_SYNTH);

    ccoc_divider u_ch4_div (
        .clock(clock),
        .srst(srst),
        .src_level(ch4_pick[0] & ch4_pick[1]),
        .ratio_code(ch4_div_r),
        .bypass(ch4_bypass),
        .out_level(ch4_div_level)
    );

    // Channel 4 clock leaves through one more flop so the port is registered.
    always_ff @(posedge clock) begin
        if (srst) begin
            ch4_clock_out <= 1'b0;
        end else begin
            ch4_clock_out <= ch4_div_level;
        end
    end

    // no source static
    // Without a valid source the level is held low, so no edge reaches a pin.
    assign ch5_valid = ch5_pick[1];
    assign ch5_level = ch5_pick[1] & ch5_pick[0];
    assign p_pin = cmos_pin(ch5_drive_mode_a, ch5_level);
    assign n_pin = cmos_pin(ch5_drive_mode_b, ch5_level);

    // Output driver decode for channel 5.
    always_comb begin
        p_out_nxt = 1'b0;
        p_oe_n_nxt = 1'b1;
        n_out_nxt = 1'b0;
        n_oe_n_nxt = 1'b1;
        tail_nxt = ccoc_pkg::TAIL_NONE;
        load_nxt = ccoc_pkg::LOAD_NONE;
        load_en_nxt = 1'b0;
        case (ch5_format)
            ccoc_pkg::FMT_OFF: begin
                p_oe_n_nxt = 1'b1;
                n_oe_n_nxt = 1'b1;
            end
            ccoc_pkg::FMT_ACDIFF: begin
                p_out_nxt = ch5_level;
                n_out_nxt = ~ch5_level;
                p_oe_n_nxt = 1'b0;
                n_oe_n_nxt = 1'b0;
                case (ch5_drive_mode_a)
                    2'h0: tail_nxt = ccoc_pkg::TAIL_4MA;
                    2'h1: tail_nxt = ccoc_pkg::TAIL_6MA;
                    default: tail_nxt = ccoc_pkg::TAIL_8MA;
                endcase
            end
            ccoc_pkg::FMT_HCSL: begin
                p_out_nxt = ch5_level;
                n_out_nxt = ~ch5_level;
                p_oe_n_nxt = 1'b0;
                n_oe_n_nxt = 1'b0;
                case (ch5_drive_mode_a)
                    2'h0: tail_nxt = ccoc_pkg::TAIL_4MA;
                    2'h1: tail_nxt = ccoc_pkg::TAIL_6MA;
                    2'h2: tail_nxt = ccoc_pkg::TAIL_8MA;
                    default: tail_nxt = ccoc_pkg::TAIL_16MA;
                endcase
                case (ch5_drive_mode_b)
                    2'h1: load_nxt = ccoc_pkg::LOAD_50;
                    2'h2: load_nxt = ccoc_pkg::LOAD_100;
                    2'h3: load_nxt = ccoc_pkg::LOAD_200;
                    default: load_nxt = ccoc_pkg::LOAD_NONE;
                endcase
                load_en_nxt = (ch5_drive_mode_b != 2'h0);
            end
            ccoc_pkg::FMT_CMOS: begin
                p_oe_n_nxt = p_pin[1];
                p_out_nxt = p_pin[0];
                n_oe_n_nxt = n_pin[1];
                n_out_nxt = n_pin[0];
            end
            default: begin
                p_oe_n_nxt = 1'b1;
                n_oe_n_nxt = 1'b1;
            end
        endcase
    end

    // Pin flops; a released pin also drives its data low to avoid toggling.
    always_ff @(posedge clock) begin
        if (srst) begin
            p_out_r <= 1'b0;
            p_oe_n_r <= 1'b1;
            n_out_r <= 1'b0;
            n_oe_n_r <= 1'b1;
        end else begin
            p_out_r <= p_out_nxt & ~p_oe_n_nxt;
            p_oe_n_r <= p_oe_n_nxt;
            n_out_r <= n_out_nxt & ~n_oe_n_nxt;
            n_oe_n_r <= n_oe_n_nxt;
        end
    end

    // Analog trim codes for the driver, held in flops like the pins.
    always_ff @(posedge clock) begin
        if (srst) begin
            tail_r <= ccoc_pkg::TAIL_NONE;
            load_r <= ccoc_pkg::LOAD_NONE;
            load_en_r <= 1'b0;
        end else begin
            tail_r <= tail_nxt;
            load_r <= load_nxt;
            load_en_r <= load_en_nxt;
        end
    end

    assign ch5_out_p = p_out_r;
    assign ch5_out_p_oe_n = p_oe_n_r;
    assign ch5_out_n = n_out_r;
    assign ch5_out_n_oe_n = n_oe_n_r;
    assign ch5_tail_current_ma = tail_r;
    assign ch5_load_ohms = load_r;
    assign ch5_load_enabled = load_en_r;

    // Live status: which channels have a source and which driver is on.
    assign ch5_active = (ch5_format != ccoc_pkg::FMT_OFF) && ch5_valid;
    always_comb begin
        status = 8'h00;
        status[ccoc_pkg::ST_CH4_VALID] = ch4_pick[1];
        status[ccoc_pkg::ST_CH4_BYPASS] = ch4_bypass;
        status[ccoc_pkg::ST_CH5_VALID] = ch5_valid;
        status[ccoc_pkg::ST_CH5_ACTIVE] = ch5_active;
    end

    // Read decode; unmapped addresses answer zero.
    always_comb begin
        case (address)
            ccoc_pkg::OFF_CH4_DIV: read_data_nxt = ch4_div_r;
            ccoc_pkg::OFF_CH5_CTL: read_data_nxt = ch5_ctl_r;
            ccoc_pkg::OFF_CH4_SRC: read_data_nxt = ch4_src_r;
            ccoc_pkg::OFF_STATUS: read_data_nxt = status;
            default: read_data_nxt = ccoc_pkg::READ_IDLE;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe, zero otherwise.
    always_ff @(posedge clock) begin
        if (srst) begin
            read_data_r <= ccoc_pkg::READ_IDLE;
        end else if (read_strobe) begin
            read_data_r <= read_data_nxt;
        end else begin
            read_data_r <= ccoc_pkg::READ_IDLE;
        end
    end

    assign read_data = read_data_r;
endmodule // clock_channel_output_config

// File: testbench/ccoc_checker.sv
// Checker for the register port and the channel output decode.
// Assumes it is bound to the top module; one clock, synchronous active-high reset.
module ccoc_checker (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [7:0] read_data,
    input wire logic primary_ref_in,
    input wire logic ch4_clock_out,
    input wire logic ch5_out_p,
    input wire logic ch5_out_p_oe_n,
    input wire logic ch5_out_n,
    input wire logic ch5_out_n_oe_n,
    input wire logic [4:0] ch5_tail_current_ma,
    input wire logic [7:0] ch5_load_ohms,
    input wire logic ch5_load_enabled
);
    logic [7:0] div_r;
    logic [7:0] ctl_r;
    logic [2:0] src4_r;
    logic [2:0] settle_r;
    logic settled;
    logic [1:0] fmt;
    logic [1:0] ma;
    logic [1:0] mb;
    logic [4:0] exp_tail;
    logic [7:0] exp_load;
    logic [7:0] exp_rd;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // Shadow copies of the registers, so outputs are judged against what software wrote.
    always_ff @(posedge clock) begin
        if (srst) begin
            div_r <= ccoc_pkg::RST_CH4_DIV;
            ctl_r <= ccoc_pkg::RST_CH5_CTL;
            src4_r <= 3'h0;
        end else if (write_strobe) begin
            if (address == ccoc_pkg::OFF_CH4_DIV) div_r <= write_data;
            if (address == ccoc_pkg::OFF_CH5_CTL) ctl_r <= write_data;
            if (address == ccoc_pkg::OFF_CH4_SRC) src4_r <= write_data[2:0];
        end
    end

    // Cycles since the last write; outputs lag by a few cycles, so judge only when settled.
    always_ff @(posedge clock) begin
        if (srst || write_strobe) begin
            settle_r <= 3'h0;
        end else if (settle_r != 3'h7) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    // Decoded fields and the values they should produce.
    assign settled = settle_r == 3'h7;
    assign fmt = ctl_r[5:4];
    assign ma = ctl_r[3:2];
    assign mb = ctl_r[1:0];
    assign exp_tail = ma == 2'h0 ? 5'h04 : ma == 2'h1 ? 5'h06 : ma == 2'h2 ? 5'h08 :
                      fmt == ccoc_pkg::FMT_HCSL ? 5'h10 : 5'h08;
    assign exp_load = mb == 2'h0 ? 8'h00 : mb == 2'h1 ? 8'h32 : mb == 2'h2 ? 8'h64 : 8'hc8;
    assign exp_rd = address == ccoc_pkg::OFF_CH4_DIV ? div_r : ctl_r;

    rd_data_a: assert property (
        read_strobe && (address == ccoc_pkg::OFF_CH4_DIV || address == ccoc_pkg::OFF_CH5_CTL)
        |=> read_data == $past(exp_rd)) else $error("register read differs from shadow");
    rd_idle_a: assert property (
        !read_strobe |=> read_data == ccoc_pkg::READ_IDLE) else $error("read data not idle");
    tail_current_a: assert property (
        settled && (fmt == ccoc_pkg::FMT_ACDIFF || fmt == ccoc_pkg::FMT_HCSL)
        |-> ch5_tail_current_ma == exp_tail) else $error("tail current wrong");
    hcsl_load_a: assert property (
        settled && fmt == ccoc_pkg::FMT_HCSL |-> ch5_load_ohms == exp_load
        && ch5_load_enabled == (mb != 2'h0)) else $error("load wrong");
    load_off_a: assert property (
        settled && fmt != ccoc_pkg::FMT_HCSL |-> ch5_load_ohms == ccoc_pkg::LOAD_NONE
        && !ch5_load_enabled) else $error("load present outside current-steering mode");
    p_tristate_a: assert property (
        settled && fmt == ccoc_pkg::FMT_CMOS && ma == ccoc_pkg::PIN_OFF_Z
        |-> ch5_out_p_oe_n) else $error("positive pin driven");
    n_low_a: assert property (
        settled && fmt == ccoc_pkg::FMT_CMOS && mb == ccoc_pkg::PIN_OFF_LOW
        |-> !ch5_out_n_oe_n && !ch5_out_n) else $error("negative pin not held low");
    p_inverted_a: assert property (
        settled && fmt == ccoc_pkg::FMT_CMOS && ctl_r[7:6] == ccoc_pkg::SRC_PRI && !src4_r[2]
        && ma == ccoc_pkg::PIN_INV |-> ch5_out_p == !$past(primary_ref_in, 3))
        else $error("positive pin polarity wrong");
    ch4_static_a: assert property (
        settled && src4_r[1:0] == ccoc_pkg::SRC_RSVD |-> !ch4_clock_out)
        else $error("channel 4 toggles without source");

    cover property (read_strobe && address == ccoc_pkg::OFF_CH4_DIV);
    cover property (settled && fmt == ccoc_pkg::FMT_HCSL);
    cover property ($rose(ch4_clock_out));
endmodule // ccoc_checker

bind clock_channel_output_config ccoc_checker u_ccoc_checker (
    .clock, .srst, .address, .write_data, .write_strobe, .read_strobe, .read_data,
    .primary_ref_in, .ch4_clock_out, .ch5_out_p, .ch5_out_p_oe_n, .ch5_out_n,
    .ch5_out_n_oe_n, .ch5_tail_current_ma, .ch5_load_ohms, .ch5_load_enabled
);

// File: testbench/clock_channel_output_config_tb.sv
// Self-checking bench for the clock channel output configuration block.
// Assumes the checker binds itself; inputs change by non-blocking assignment at rising edges.
module clock_channel_output_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] address = 8'h00;
    logic [7:0] write_data = 8'h00;
    logic write_strobe = 1'b0;
    logic read_strobe = 1'b0;
    logic [4:0] lvl = 5'h00;
    logic [7:0] read_data;
    logic ch4_clock_out;
    logic ch4_q = 1'b0;
    logic ch5_out_p;
    logic ch5_out_p_oe_n;
    logic ch5_out_n;
    logic ch5_out_n_oe_n;
    logic [4:0] ch5_tail_current_ma;
    logic [7:0] ch5_load_ohms;
    logic ch5_load_enabled;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;
    int rises = 0;
    logic [4:0] tail_tab [2][4] = '{'{5'h04, 5'h06, 5'h08, 5'h08}, '{5'h04, 5'h06, 5'h08, 5'h10}};
    logic [7:0] load_tab [4] = '{8'h00, 8'h32, 8'h64, 8'hc8};
    logic [7:0] t_sel [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h06, 8'h06, 8'h01};
    logic [7:0] t_div [9] = '{8'h00, 8'h01, 8'h02, 8'hff, 8'h05, 8'h05, 8'h05, 8'h05, 8'h00};
    int t_in [9] = '{0, 0, 0, 0, 1, 2, 3, 1, 0};
    int t_n [9] = '{3, 6, 9, 768, 6, 6, 6, 6, 6};
    int t_exp [9] = '{3, 3, 3, 3, 6, 6, 6, 0, 0};

    clock_channel_output_config uut (
        .clock, .srst, .address, .write_data, .write_strobe, .read_strobe, .read_data,
        .second_synth_output(lvl[0]), .primary_ref_in(lvl[1]), .secondary_ref_in(lvl[2]),
        .primary_ref_doubled_in(lvl[3]), .secondary_ref_doubled_in(lvl[4]),
        .ch4_clock_out, .ch5_out_p, .ch5_out_p_oe_n, .ch5_out_n, .ch5_out_n_oe_n,
        .ch5_tail_current_ma, .ch5_load_ohms, .ch5_load_enabled
    );

    // The 50 MHz system clock.
    always #10 clock = ~clock;

    // Counts channel 4 rising edges and cuts a hung run short.
    always @(posedge clock) begin
        cycles++;
        ch4_q <= ch4_clock_out;
        if (ch4_clock_out && !ch4_q) rises++;
        if (cycles == LIMIT) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-way through it.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        @(negedge clock);
        check(what, exp, read_data);
    endtask

    // Outputs trail the registers and the synchronisers by a few cycles.
    task automatic pause();
        repeat (8) @(posedge clock);
        @(negedge clock);
    endtask

    // Each pulse is eight system cycles, slow enough for the two-flop sampling.
    task automatic pulses(input int idx, input int n);
        @(posedge clock);
        repeat (n) begin
            lvl[idx] <= 1'b1;
            repeat (4) @(posedge clock);
            lvl[idx] <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask

    // Enable-low bit above the data bit for one single-ended pin.
    function automatic logic [1:0] pin_exp(input logic [1:0] m, input logic b);
        case (m)
            2'h0: return 2'b10;
            2'h1: return 2'b00;
            2'h2: return {1'b0, ~b};
            default: return {1'b0, b};
        endcase
    endfunction

    // Level expected on a true-polarity pin; bit 2 of s is the doubler.
    function automatic logic src_exp(input int s, input logic [4:0] l);
        case (s % 4)
            0: return l[0];
            2: return s > 3 ? l[3] : l[1];
            3: return s > 3 ? l[4] : l[2];
            default: return 1'b0;
        endcase
    endfunction

    // Main sequence.
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        pause();
        check("reset tail", 8'h08, 8'(ch5_tail_current_ma));
        rd_chk(8'h26, 8'h02, "divider reset");
        rd_chk(8'h27, 8'h18, "control reset");
        rd_chk(8'h40, 8'h00, "unmapped read");
        wr(8'h26, 8'ha5);
        rd_chk(8'h26, 8'ha5, "divider rw");
        wr(8'h26, 8'h5a);
        rd_chk(8'h26, 8'h5a, "divider rw");
        for (int f = 1; f < 3; f++) begin
            for (int m = 0; m < 4; m++) begin
                wr(8'h27, {2'h2, 2'(f), 2'(m), 2'(m)});
                pause();
                check("tail", 8'(tail_tab[f - 1][m]), 8'(ch5_tail_current_ma));
                check("load", f == 2 ? load_tab[m] : 8'h00, ch5_load_ohms);
                check("load on", 8'(f == 2 && m != 0), 8'(ch5_load_enabled));
            end
        end
        for (int b = 0; b < 2; b++) begin
            for (int m = 0; m < 4; m++) begin
                @(posedge clock);
                lvl[1] <= 1'(b);
                wr(8'h27, {2'h2, 2'h3, 2'(m), 2'(3 - m)});
                pause();
                check("pin p", 8'(pin_exp(2'(m), 1'(b))), 8'({ch5_out_p_oe_n, ch5_out_p}));
                check("pin n", 8'(pin_exp(2'(3 - m), 1'(b))),
                      8'({ch5_out_n_oe_n, ch5_out_n}));
            end
        end
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 8; s++) begin
                @(posedge clock);
                lvl <= p ? 5'h0d : 5'h12;
                wr(8'h30, 8'(s));
                wr(8'h27, {2'(s), 6'h3f});
                pause();
                check("source", 8'(src_exp(s, lvl)), 8'(ch5_out_p));
                // The source register keeps three bits; status shows which choices are usable.
                rd_chk(8'h30, 8'(s), "source rw");
                rd_chk(8'h31, s % 4 == 1 ? 8'h02 : s % 4 == 0 ? 8'h0d : 8'h0f, "status");
            end
        end
        @(posedge clock);
        lvl <= 5'h00;
        for (int i = 0; i < 9; i++) begin
            wr(8'h30, t_sel[i]);
            wr(8'h26, t_div[i]);
            pause();
            rises = 0;
            pulses(t_in[i], t_n[i]);
            pause();
            check("ch4 edges", 8'(t_exp[i]), 8'(rises));
        end
        // A second reset in mid-run must return the divider to its reset value.
        // The last check left us at a falling edge, so step to a rising edge first.
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd_chk(8'h26, 8'h02, "divider after reset");
        print_verdict();
    end
endmodule // clock_channel_output_config_tb
